/* File: logic/uart_defines.vh */
// Register offsets, field positions, codes and timing for the serial port
`ifndef UART_DEFINES_VH
`define UART_DEFINES_VH
`define MODE_OFFSET      12'h000
`define STATUS_OFFSET    12'h004
`define TXDATA_OFFSET    12'h008
`define RXDATA_OFFSET    12'h00c
`define DIVISOR_OFFSET   12'h010
`define MODE_STOP        0
`define MODE_FMT_LO      1
`define MODE_FMT_HI      2
`define MODE_HIGH_SPEED  3
`define MODE_AUTO_RATE   5
`define MODE_LOOPBACK    6
`define MODE_INFRARED    12
`define MODE_ENABLE      15
`define ST_RX_AVAIL      0
`define ST_OVERRUN       1
`define ST_FRAME_ERR     2
`define ST_PARITY_ERR    3
`define ST_ADDR_DETECT   5
`define ST_TX_IDLE       8
`define ST_TX_FULL       9
`define ST_TX_ENABLE     10
`define ST_BREAK         11
`define ST_TXI_LO        13
`define ST_TXI_HI        15
`define ST_TX_IRQ        16
`define FMT_8N           2'h0
`define FMT_8E           2'h1
`define FMT_8O           2'h2
`define FMT_9N           2'h3
`define TXI_EACH         2'h0
`define TXI_DONE         2'h1
`define TXI_EMPTY        2'h2
`define SLOW_TICKS       4'hf
`define FAST_TICKS       4'h3
`define BREAK_ZEROS      12
`define SYNC_VALUE       9'h055
`endif

/* File: logic/uart_baud_and_transmit.v */
// Full-duplex serial port with baud timer, FIFOs, break and APB registers
// Functional notes
// - 16-bit timer; standard rate Fcy/16(div+1)
// - High-speed rate Fcy/4(div+1)
// - Divisor write clears baud timer immediately
// - 8/9-bit, even/odd/no parity, 1-2 stops
// - Four-deep transmit and receive queues
// - Flag parity, framing, overrun errors
// - 9-bit address detect on ninth bit
// - Enabling transmit raises transmit interrupt
// - 8-bit byte write loads shifter at once
// - Enable after load starts immediately
// - 9-bit mode needs word write
// - Break, dummy, then 55h header sequence
// - Hardware clears break request, sends sync
// - Transmit interrupt at selected point
// - Loopback routes transmit into receiver
// - Auto baud measures incoming sync character
// - Infrared codec and 16x clock output; no codec here, the bit only gates baud_x16_clk
// - High-speed gives 4 ticks per bit
// - Frame format codes 00,01,10,11
// - Break: start, twelve zeros, stop
// - Interrupt modes each/done/empty, 11 reserved
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "uart_defines.vh"
module uart_baud_and_transmit #(
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        serial_in_pin,
    output reg         serial_out_pin,
    output reg         tx_irq,
    output reg         rx_irq,
    output reg         baud_x16_clk
);
    // Configuration
    reg [15:0] baud_divisor;
    reg        enable;
    reg        infrared_codec_enable;
    reg        loopback_select;
    reg        auto_rate_enable;
    reg        high_speed_baud_select;
    reg [1:0]  frame_format_select;
    reg        stop_bit_select;
    reg        transmit_enable_bit;
    reg        break_request;
    reg [1:0]  tx_interrupt_select;
    reg        address_detect_enable;
    reg        overrun;
    reg        tx_irq_flag;

    wire acc   = psel & penable;
    wire wr    = acc & pwrite;
    wire nine  = (frame_format_select == `FMT_9N);
    wire [3:0] ticks_per_bit = high_speed_baud_select ? `FAST_TICKS : `SLOW_TICKS;

    // Baud timer; tick is one oversample clock
    reg  [15:0] baud_cnt;
    reg         tx_en_d;
    wire        div_wr = wr && paddr == `DIVISOR_OFFSET;
    wire        tick   = enable && baud_cnt == baud_divisor;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            baud_cnt <= 16'h0000;
        else if (div_wr || !enable || (transmit_enable_bit && !tx_en_d))
            baud_cnt <= 16'h0000;
        else if (tick)
            baud_cnt <= 16'h0000;
        else
            baud_cnt <= baud_cnt + 16'h0001;
    end

    // Transmit queue (9 bits wide)
    reg [8:0]  txq [0:DEPTH-1];
    reg [AW:0] tx_cnt;
    reg [AW-1:0] tx_wp, tx_rp;
    wire tx_full  = tx_cnt == DEPTH;
    wire tx_empty = tx_cnt == 0;
    // Byte lane write fills 8-bit mode; 9-bit mode needs both low lanes
    wire tx_push = wr && paddr == `TXDATA_OFFSET && !tx_full &&
                   (nine ? (pstrb[1:0] == 2'b11) : pstrb[0]);
    wire tx_pop;

    // Transmitter state
    localparam TX_IDLE = 2'd0, TX_SHIFT = 2'd1;
    reg [1:0]  tx_state;
    reg [13:0] tx_sr;
    reg [3:0]  tx_bits;
    reg [3:0]  tx_tick;
    reg        tx_is_break;
    assign tx_pop = transmit_enable_bit && tx_state == TX_IDLE && !tx_empty;
    wire [8:0] tx_head = txq[tx_rp];
    wire par = ^tx_head[7:0] ^ (frame_format_select == `FMT_8O);
    wire tx_bit_end = tick && tx_tick == ticks_per_bit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt <= 0; tx_wp <= 0; tx_rp <= 0;
            tx_state <= TX_IDLE; tx_sr <= 14'h3fff; tx_bits <= 4'h0;
            tx_tick <= 4'h0; tx_is_break <= 1'b0; serial_out_pin <= 1'b1;
        end else if (!transmit_enable_bit) begin
            tx_state <= TX_IDLE; serial_out_pin <= 1'b1;
            if (tx_push) begin
                txq[tx_wp] <= pwdata[8:0]; tx_wp <= tx_wp + 1'b1; tx_cnt <= tx_cnt + 1'b1;
            end
        end else begin
            if (tx_push) txq[tx_wp] <= pwdata[8:0];
            if (tx_push) tx_wp <= tx_wp + 1'b1;
            tx_cnt <= tx_cnt + (tx_push ? 1'b1 : 1'b0) - (tx_pop ? 1'b1 : 1'b0);
            case (tx_state)
            TX_IDLE: begin
                serial_out_pin <= 1'b1;
                if (tx_pop) begin
                    tx_rp <= tx_rp + 1'b1;
                    tx_tick <= 4'h0;
                    tx_state <= TX_SHIFT;
                    tx_is_break <= break_request;
                    if (break_request) begin
                        tx_sr <= 14'h0000; tx_bits <= 4'd14;
                    end else begin
                        // Start, data LSB first, parity or ninth bit, stops;
                        // With no parity the slot above the data is already a stop
                        tx_sr <= {2'b11, (nine ? tx_head[8] :
                                  ((frame_format_select != `FMT_8N) ? par : 1'b1)),
                                  tx_head[7:0], 1'b0};
                        tx_bits <= 4'd9 + ((frame_format_select != `FMT_8N) ? 4'd1 : 4'd0)
                                   + (stop_bit_select ? 4'd2 : 4'd1);
                    end
                end
            end
            default: begin
                serial_out_pin <= tx_sr[0];
                if (tick) tx_tick <= (tx_tick == ticks_per_bit) ? 4'h0 : tx_tick + 4'h1;
                if (tx_bit_end) begin
                    tx_sr <= {1'b1, tx_sr[13:1]};
                    if (tx_is_break && tx_bits == 4'd2) tx_sr[0] <= 1'b1; // stop of break
                    tx_bits <= tx_bits - 4'h1;
                    if (tx_bits == 4'h1) tx_state <= TX_IDLE;
                end
            end
            endcase
        end
    end
    wire tx_done = tx_state == TX_SHIFT && tx_bit_end && tx_bits == 4'h1;

    // Receiver: 16x or 4x oversample, centre sampled
    wire rx_line = loopback_select ? serial_out_pin : serial_in_pin;
    reg        rx_busy;
    reg [3:0]  rx_tick, rx_bits;
    reg [10:0] rx_sr;
    reg [11:0] rxq [0:DEPTH-1];
    reg [AW:0] rx_cnt;
    reg [AW-1:0] rx_wp, rx_rp;
    reg [15:0] auto_cnt;
    reg [3:0]  auto_edges;
    reg        rx_prev;
    wire [3:0] rx_len = 4'd9 + ((frame_format_select != `FMT_8N) ? 4'd1 : 4'd0);
    wire rx_pop = acc && !pwrite && paddr == `RXDATA_OFFSET && rx_cnt != 0;
    wire rx_sample = tick && rx_tick == {1'b0, ticks_per_bit[3:1]};
    wire rx_end = rx_busy && rx_sample && rx_bits == rx_len;
    wire [8:0] rx_data = nine ? rx_sr[9:1] : {1'b0, rx_sr[8:1]};
    wire rx_perr = !nine && frame_format_select != `FMT_8N &&
                   (^rx_sr[9:1] ^ (frame_format_select == `FMT_8O));
    wire rx_ferr = !rx_line;
    wire rx_keep = !(address_detect_enable && nine && !rx_data[8]);
    wire rx_store = rx_end && rx_keep && rx_cnt != DEPTH;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_busy <= 1'b0; rx_tick <= 4'h0; rx_bits <= 4'h0; rx_sr <= 11'h000;
            rx_cnt <= 0; rx_wp <= 0; rx_rp <= 0; rx_prev <= 1'b1;
        end else begin
            rx_prev <= rx_line;
            if (!rx_busy) begin
                if (enable && !rx_line && !auto_rate_enable) begin
                    rx_busy <= 1'b1; rx_tick <= 4'h0; rx_bits <= 4'h0;
                end
            end else if (tick) begin
                rx_tick <= (rx_tick == ticks_per_bit) ? 4'h0 : rx_tick + 4'h1;
                if (rx_sample) begin
                    rx_sr[rx_bits] <= rx_line;
                    rx_bits <= rx_bits + 4'h1;
                    if (rx_bits == 4'h0 && rx_line) rx_busy <= 1'b0; // false start
                    if (rx_end) rx_busy <= 1'b0;
                end
            end
            if (rx_store) begin
                rxq[rx_wp] <= {address_detect_enable & rx_data[8], rx_perr, rx_ferr, rx_data};
                rx_wp <= rx_wp + 1'b1;
            end
            if (rx_pop) rx_rp <= rx_rp + 1'b1;
            rx_cnt <= rx_cnt + (rx_store ? 1'b1 : 1'b0) - (rx_pop ? 1'b1 : 1'b0);
        end
    end

    // Auto baud: count clocks over the sync's eight bit times (edges 1..5)
    wire fall = rx_prev && !rx_line;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_cnt <= 16'h0000; auto_edges <= 4'h0;
        end else if (!auto_rate_enable) begin
            auto_cnt <= 16'h0000; auto_edges <= 4'h0;
        end else begin
            if (auto_edges != 4'h0) auto_cnt <= auto_cnt + 16'h0001;
            if (fall) auto_edges <= auto_edges + 4'h1;
        end
    end
    wire auto_done = auto_rate_enable && fall && auto_edges == 4'h4;
    // Eight bits of 16 or 4 ticks: divisor = count/128 or count/32, less one
    wire [15:0] auto_div = (high_speed_baud_select ? {5'h00, auto_cnt[15:5]}
                                                   : {7'h00, auto_cnt[15:7]}) - 16'h0001;

    // Register writes and hardware-set flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_divisor <= 16'h0000; enable <= 1'b0; infrared_codec_enable <= 1'b0;
            loopback_select <= 1'b0; auto_rate_enable <= 1'b0; high_speed_baud_select <= 1'b0;
            frame_format_select <= `FMT_8N; stop_bit_select <= 1'b0;
            transmit_enable_bit <= 1'b0; break_request <= 1'b0; tx_interrupt_select <= `TXI_EACH;
            address_detect_enable <= 1'b0; overrun <= 1'b0; tx_irq_flag <= 1'b0; tx_en_d <= 1'b0;
        end else begin
            tx_en_d <= transmit_enable_bit;
            if (div_wr) baud_divisor <= pwdata[15:0];
            if (wr && paddr == `MODE_OFFSET) begin
                enable <= pwdata[`MODE_ENABLE];
                infrared_codec_enable <= pwdata[`MODE_INFRARED];
                loopback_select <= pwdata[`MODE_LOOPBACK];
                auto_rate_enable <= pwdata[`MODE_AUTO_RATE];
                high_speed_baud_select <= pwdata[`MODE_HIGH_SPEED];
                frame_format_select <= pwdata[`MODE_FMT_HI:`MODE_FMT_LO];
                stop_bit_select <= pwdata[`MODE_STOP];
            end
            if (auto_done) begin
                auto_rate_enable <= 1'b0;
                baud_divisor <= auto_div;
            end
            if (wr && paddr == `STATUS_OFFSET) begin
                transmit_enable_bit <= pwdata[`ST_TX_ENABLE];
                break_request <= pwdata[`ST_BREAK];
                tx_interrupt_select <= {pwdata[`ST_TXI_HI], pwdata[`ST_TXI_LO]};
                address_detect_enable <= pwdata[`ST_ADDR_DETECT];
                if (!pwdata[`ST_OVERRUN]) overrun <= 1'b0;
                if (!pwdata[`ST_TX_IRQ]) tx_irq_flag <= 1'b0;
            end
            if (tx_done && tx_is_break) break_request <= 1'b0;
            // Set wins over a same-cycle clear
            if (rx_end && rx_keep && rx_cnt == DEPTH) overrun <= 1'b1;
            if ((transmit_enable_bit && !tx_en_d) ||
                (tx_pop && tx_interrupt_select == `TXI_EACH) ||
                (tx_done && tx_empty && tx_interrupt_select == `TXI_DONE) ||
                (tx_pop && tx_cnt == 1 && !tx_push && tx_interrupt_select == `TXI_EMPTY))
                tx_irq_flag <= 1'b1;
        end
    end

    // APB read path, one wait-free access phase
    wire [11:0] rx_head = rxq[rx_rp];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000; pready <= 1'b0; pslverr <= 1'b0;
            tx_irq <= 1'b0; rx_irq <= 1'b0; baud_x16_clk <= 1'b0;
        end else begin
            tx_irq <= tx_irq_flag;
            rx_irq <= rx_cnt != 0;
            // 16x clock output only meaningful in standard-speed mode
            baud_x16_clk <= (infrared_codec_enable && !high_speed_baud_select) ?
                            (tick ? ~baud_x16_clk : baud_x16_clk) : 1'b0;
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                if (paddr == `MODE_OFFSET)
                    prdata <= {16'h0000, enable, 2'b00, infrared_codec_enable, 5'h00,
                               loopback_select, auto_rate_enable, 1'b0,
                               high_speed_baud_select, frame_format_select, stop_bit_select};
                else if (paddr == `STATUS_OFFSET)
                    prdata <= {15'h0000, tx_irq_flag, tx_interrupt_select[1], 1'b0,
                               tx_interrupt_select[0], 1'b0, break_request,
                               transmit_enable_bit, tx_full,
                               (tx_empty && tx_state == TX_IDLE), 2'b00,
                               address_detect_enable, 1'b0,
                               rx_cnt != 0 && rx_head[10], rx_cnt != 0 && rx_head[9],
                               overrun, rx_cnt != 0};
                else if (paddr == `RXDATA_OFFSET)
                    prdata <= {20'h00000, rx_head[11], 2'b00, rx_head[8:0]};
                else if (paddr == `DIVISOR_OFFSET)
                    prdata <= {16'h0000, baud_divisor};
                else if (paddr != `TXDATA_OFFSET)
                    pslverr <= 1'b1;
            end else if (psel && !penable && paddr != `MODE_OFFSET &&
                         paddr != `STATUS_OFFSET && paddr != `TXDATA_OFFSET &&
                         paddr != `DIVISOR_OFFSET) begin
                pslverr <= 1'b1;
            end
        end
    end
endmodule

/* File: testbench/uart_baud_and_transmit_chk.sv */
// Port-level checks for the serial port block
`timescale 1ns/100ps
module uart_baud_and_transmit_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        serial_in_pin,
    input wire        serial_out_pin,
    input wire        tx_irq,
    input wire        rx_irq,
    input wire        baud_x16_clk
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    property p_ready_one;
        pready |=> !pready;
    endproperty
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_err_unmapped;
        psel && !penable && paddr > 12'h010 |=> pslverr;
    endproperty
    property p_err_mapped;
        psel && !penable && paddr <= 12'h010 && paddr[1:0] == 2'b00 |=> !pslverr;
    endproperty
    property p_idle_no_ready;
        !psel |=> !pready;
    endproperty
    // Shortest bit is four clocks, so any edge holds three more
    property p_bit_hold;
        $changed(serial_out_pin) |=> $stable(serial_out_pin) [*3];
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("No answer after setup");
    a_ready_one: assert property (p_ready_one)
        else $error("Answer longer than one cycle");
    a_ready_in_access: assert property (p_ready_in_access)
        else $error("Answer outside access phase");
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("Error without answer");
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("Unmapped address accepted");
    a_err_mapped: assert property (p_err_mapped)
        else $error("Mapped address refused");
    a_idle_no_ready: assert property (p_idle_no_ready)
        else $error("Answer without select");
    a_bit_hold: assert property (p_bit_hold)
        else $error("Line bit shorter than four clocks");
    c_err: cover property (pslverr);
    c_start: cover property ($fell(serial_out_pin));
    c_rx: cover property ($rose(rx_irq));
    c_tx: cover property ($rose(tx_irq));
endmodule
bind uart_baud_and_transmit uart_baud_and_transmit_chk uart_baud_and_transmit_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .baud_x16_clk(baud_x16_clk));

/* File: testbench/uart_line_partner.sv */
// Far-side serial line model: frame capture and frame sender
`timescale 1ns/100ps
module uart_line_partner (
    input  wire        pclk,
    input  wire [15:0] bit_clks,
    input  wire        serial_out_pin,
    output reg         line_out
);
    initial line_out = 1'b1;
    // Samples mid-bit; returns all ones if no start bit shows up
    task capture(input [3:0] len, output [15:0] frame);
        integer n;
        integer k;
        begin
            frame = 16'h0000;
            n = 0;
            while (serial_out_pin !== 1'b0 && n < 4000) begin
                @(posedge pclk);
                n = n + 1;
            end
            if (n >= 4000)
                frame = 16'hffff;
            else
                for (k = 0; k < len; k = k + 1) begin
                    repeat (k == 0 ? bit_clks / 2 : bit_clks) @(posedge pclk);
                    frame[k] = serial_out_pin;
                end
        end
    endtask
    task send(input [7:0] data, input stop_val);
        integer k;
        reg [9:0] bits;
        begin
            bits = {stop_val, data, 1'b0};
            for (k = 0; k < 10; k = k + 1) begin
                line_out <= bits[k];
                repeat (bit_clks) @(posedge pclk);
            end
            line_out <= 1'b1;
            repeat (bit_clks) @(posedge pclk);
        end
    endtask
endmodule

/* File: testbench/test_uart_baud_and_transmit.sv */
// Self-checking bench for the serial port block
`timescale 1ns/100ps
`include "uart_defines.vh"
module test_uart_baud_and_transmit;
    typedef struct packed {logic [15:0] mode; logic [8:0] data; logic [3:0] len;
        logic [15:0] frame;} row_t;
    reg         pclk      = 1'b0;
    reg         presetn   = 1'b0;
    reg         psel      = 1'b0;
    reg         penable   = 1'b0;
    reg         pwrite    = 1'b0;
    reg  [11:0] paddr     = 12'h000;
    reg  [31:0] pwdata    = 32'h0;
    reg  [3:0]  pstrb     = 4'hf;
    reg  [15:0] bit_clks  = 16'h0020;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        serial_in_pin;
    wire        serial_out_pin;
    wire        tx_irq;
    wire        rx_irq;
    integer     err_total = 0;
    integer     tests_run = 0;
    integer     i;
    integer     lows;
    reg  [31:0] rd;
    reg         er;
    reg  [15:0] frame;
    row_t       rows [0:4] = '{'{16'h8000, 9'h0a5, 4'd10, 16'h034a},
        '{16'h8002, 9'h0a5, 4'd11, 16'h054a}, '{16'h8005, 9'h0a5, 4'd12, 16'h0f4a},
        '{16'h8006, 9'h1a5, 4'd11, 16'h074a}, '{16'h8008, 9'h03c, 4'd10, 16'h0278}};
    always #12.5 pclk = ~pclk;
    uart_baud_and_transmit uart_baud_and_transmit_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
        .tx_irq(tx_irq), .rx_irq(rx_irq), .baud_x16_clk());
    uart_line_partner uart_line_partner_inst (
        .pclk(pclk), .bit_clks(bit_clks), .serial_out_pin(serial_out_pin),
        .line_out(serial_in_pin));
    task wrap_up;
        begin
            $display("Checks %0d, mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task bail(input integer n);
        begin
            if (n >= 2000) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t wait ran out", $time);
                wrap_up;
            end
        end
    endtask
    // Idle cycle first, so back-to-back calls never drive psel twice at once
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            // Look at the answer mid-cycle, where it has settled
            do begin
                @(negedge pclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 2000);
            rd = prdata;
            er = pslverr;
            @(posedge pclk);
            psel <= 1'b0;
            penable <= 1'b0;
            bail(n);
        end
    endtask
    task wait_rx;
        integer n;
        begin
            n = 0;
            while (rx_irq !== 1'b1 && n < 2000) begin
                @(posedge pclk);
                n = n + 1;
            end
            bail(n);
        end
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MODE_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `DIVISOR_OFFSET, 32'h1);
        apb(1'b1, `MODE_OFFSET, 32'h8000);
        apb(1'b1, `STATUS_OFFSET, 32'h0400);
        repeat (3) @(posedge pclk);
        chk(tx_irq, 1);
        for (i = 0; i < 5; i = i + 1) begin
            apb(1'b1, `MODE_OFFSET, rows[i].mode);
            bit_clks = rows[i].mode[3] ? 16'd8 : 16'd32;
            apb(1'b1, `STATUS_OFFSET, 32'h2400);
            fork
                uart_line_partner_inst.capture(rows[i].len, frame);
                begin
                    apb(1'b1, `TXDATA_OFFSET, {23'h0, rows[i].data});
                    repeat (3) @(posedge pclk);
                    chk(tx_irq, 0);
                end
            join
            chk(frame, rows[i].frame);
            repeat (bit_clks) @(posedge pclk);
            chk(tx_irq, 1);
            $display("Frame row %0d done", i);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk(er, 1);
        apb(1'b1, `MODE_OFFSET, 32'h8006);
        pstrb <= 4'h1;
        apb(1'b1, `TXDATA_OFFSET, 32'h1a5);
        pstrb <= 4'hf;
        lows = 0;
        repeat (96) begin
            @(posedge pclk);
            if (serial_out_pin !== 1'b1) lows = lows + 1;
        end
        chk(lows, 0);
        $display("Byte write in 9-bit mode done");
        apb(1'b1, `MODE_OFFSET, 32'h8000);
        bit_clks = 16'd32;
        apb(1'b1, `STATUS_OFFSET, 32'h0c00);
        fork
            uart_line_partner_inst.capture(4'd14, frame);
            begin
                apb(1'b1, `TXDATA_OFFSET, 32'h0ff);
                apb(1'b1, `TXDATA_OFFSET, 32'h055);
            end
        join
        chk(frame, 16'h2000);
        uart_line_partner_inst.capture(4'd10, frame);
        chk(frame, 16'h02aa);
        apb(1'b0, `STATUS_OFFSET, 32'h0);
        chk(rd[11], 0);
        $display("Break and sync done");
        apb(1'b1, `MODE_OFFSET, 32'h8040);
        apb(1'b1, `TXDATA_OFFSET, 32'h03c);
        wait_rx;
        apb(1'b0, `RXDATA_OFFSET, 32'h0);
        chk(rd[8:0], 32'h03c);
        $display("Loopback done");
        apb(1'b1, `MODE_OFFSET, 32'h8000);
        for (i = 0; i < 5; i = i + 1)
            uart_line_partner_inst.send(8'h30 + i, 1'b1);
        apb(1'b0, `STATUS_OFFSET, 32'h0);
        chk(rd[1:0], 32'h3);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b0, `RXDATA_OFFSET, 32'h0);
            chk(rd[8:0], 32'h30 + i);
        end
        apb(1'b1, `STATUS_OFFSET, 32'h0400);
        uart_line_partner_inst.send(8'h11, 1'b0);
        wait_rx;
        apb(1'b0, `STATUS_OFFSET, 32'h0);
        chk(rd[2], 1);
        $display("Receive queue and errors done");
        wrap_up;
    end
endmodule
